// ===== logic/usb_device_top_control.v
// Our own choices: the address-and-strobe port and the placing of the registers.
`include "usb_control_regs.vh"
`default_nettype none

module usb_device_top_control #(
    parameter [`RESUME_CNT_WIDTH-1:0] RESUME_HOLD_CYCLES =
        `RESUME_HOLD_CYCLES
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    // Configuration block, same clock
    input  wire        pullup_config_enable,
    input  wire [1:0]  pingpong_config,
    // Engine and bus indications, outside this domain
    input  wire        bus_se0_raw,
    input  wire        setup_token_toggle,
    // Engine control
    output reg         engine_enable,
    output reg         engine_clock_enable,
    output wire        packet_processing_disable,
    output reg         pingpong_buffer_indicator_clear,
    output reg         pingpong_pointer_force_even,
    output reg         pullup_drive,
    output reg         resume_drive,
    output reg         transceiver_idle,
    // Interrupt
    output wire        irq
);

    // --------------------------------------------------------
    // Decoding helpers
    // --------------------------------------------------------

    // One address compare shared by all write paths
    function hit;
        input [3:0] addr;
        input [3:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // --------------------------------------------------------
    // Declarations
    // --------------------------------------------------------

    reg                          pingpong_pointer_reset;
    reg                          pkt_disable;
    reg                          module_enable;
    reg                          resume_request;
    reg                          suspend_request;
    reg                          enable_q;
    reg                          se0_q;
    reg                          setup_q;
    reg  [`IRQ_WIDTH-1:0]        irq_status;
    reg  [`IRQ_WIDTH-1:0]        irq_mask;
    reg  [`RESUME_CNT_WIDTH-1:0] resume_count;
    reg                          resume_held;
    reg                          resume_held_q;
    reg                          next_pkt_disable;
    reg  [`IRQ_WIDTH-1:0]        irq_event;
    reg  [7:0]                   next_rdata;
    wire [1:0]                   sync_q;
    wire                         live_single_ended_zero;
    wire                         setup_sync;
    wire                         setup_event;
    wire                         ctl_write;
    wire                         status_write;
    wire                         mask_write;
    wire                         pingpong_mode;
    wire [7:0]                   control_view;
    wire [7:0]                   state_view;

    // --------------------------------------------------------
    // Crossing from the bus and engine side
    // --------------------------------------------------------

    // Both inputs come from outside this clock, so two flops each
    sync_two_ff #(
        .WIDTH (2)
    ) u_in_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        ({setup_token_toggle, bus_se0_raw}),
        .q        (sync_q)
    );

    assign live_single_ended_zero = sync_q[0];
    assign setup_sync             = sync_q[1];

    // SETUP arrives as a toggle, so each change is one token
    assign setup_event = (setup_sync ^ setup_q) & module_enable;

    // Delayed copies for edge detection of synchronised levels
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            se0_q         <= 1'b0;
            setup_q       <= 1'b0;
            enable_q      <= 1'b0;
            resume_held_q <= 1'b0;
        end else begin
            se0_q         <= live_single_ended_zero;
            setup_q       <= setup_sync;
            enable_q      <= module_enable;
            resume_held_q <= resume_held;
        end
    end

    // --------------------------------------------------------
    // Write decode
    // --------------------------------------------------------

    assign ctl_write    = reg_write & hit(reg_addr, `USB_CONTROL_ADDR);
    assign status_write = reg_write & hit(reg_addr, `IRQ_STATUS_ADDR);
    assign mask_write   = reg_write & hit(reg_addr, `IRQ_MASK_ADDR);

    // --------------------------------------------------------
    // Control register
    // --------------------------------------------------------

    // Plain read/write bits; all start cleared
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pingpong_pointer_reset <= 1'b0;
            module_enable          <= 1'b0;
            resume_request         <= 1'b0;
            suspend_request        <= 1'b0;
        end else if (ctl_write) begin
            // The pointer reset bit is only ever cleared here
            pingpong_pointer_reset <= reg_wdata[`CTL_PP_RESET_BIT];
            module_enable          <= reg_wdata[`CTL_ENABLE_BIT];
            resume_request         <= reg_wdata[`CTL_RESUME_BIT];
            suspend_request        <= reg_wdata[`CTL_SUSPEND_BIT];
        end
    end

    // Packet disable: hardware sets, software may only clear.
    // A token landing in the clearing cycle keeps the flag set.
    always @* begin
        next_pkt_disable = pkt_disable;
        if (ctl_write && !reg_wdata[`CTL_PKT_DISABLE_BIT]) begin
            next_pkt_disable = 1'b0;
        end
        if (setup_event) begin
            next_pkt_disable = 1'b1;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_disable <= 1'b0;
        end else begin
            pkt_disable <= next_pkt_disable;
        end
    end

    // Halt reaches the engine only while the module is on
    assign packet_processing_disable = pkt_disable & module_enable;

    // --------------------------------------------------------
    // Ping-pong configuration
    // --------------------------------------------------------

    // With no ping-pong mode the pointer reset has nothing to act on
    assign pingpong_mode = (pingpong_config != `PP_MODE_NONE);

    // --------------------------------------------------------
    // Remote wake-up timer
    // --------------------------------------------------------

    // Counts how long resume has been driven. Firmware owns the
    // timing; this only reports when the hold time has elapsed.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resume_count <= {`RESUME_CNT_WIDTH{1'b0}};
            resume_held  <= 1'b0;
        end else if (!resume_drive) begin
            resume_count <= {`RESUME_CNT_WIDTH{1'b0}};
            resume_held  <= 1'b0;
        end else if (resume_count != RESUME_HOLD_CYCLES) begin
            resume_count <= resume_count +
                            {{(`RESUME_CNT_WIDTH-1){1'b0}}, 1'b1};
        end else begin
            resume_held  <= 1'b1;
        end
    end

    // --------------------------------------------------------
    // Engine and transceiver controls
    // --------------------------------------------------------

    // Registered so the engine sees clean levels; every control
    // is qualified by enable so a disabled module stays inert.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            engine_enable                   <= 1'b0;
            engine_clock_enable             <= 1'b0;
            pingpong_buffer_indicator_clear <= 1'b0;
            pingpong_pointer_force_even     <= 1'b0;
            pullup_drive                    <= 1'b0;
            resume_drive                    <= 1'b0;
            transceiver_idle                <= 1'b0;
        end else begin
            engine_enable <= module_enable;
            // Suspend gates the engine clock to save power
            engine_clock_enable <= module_enable &
                                   ~suspend_request;
            // One pulse on the enable edge clears every indicator
            pingpong_buffer_indicator_clear <= module_enable &
                                               ~enable_q;
            pingpong_pointer_force_even <= module_enable &
                                           pingpong_pointer_reset &
                                           pingpong_mode;
            // Soft attach: pull-up follows enable when configured
            pullup_drive <= module_enable &
                            pullup_config_enable;
            // Resume is not driven while the engine clock is off
            resume_drive <= module_enable & resume_request &
                            ~suspend_request;
            // Still attached in suspend, but outputs held idle
            transceiver_idle <= module_enable &
                                suspend_request;
        end
    end

    // --------------------------------------------------------
    // Interrupt events
    // --------------------------------------------------------

    always @* begin
        irq_event = {`IRQ_WIDTH{1'b0}};
        irq_event[`IRQ_SETUP_BIT]       = setup_event;
        irq_event[`IRQ_SE0_START_BIT]   = module_enable &
                                          live_single_ended_zero &
                                          ~se0_q;
        irq_event[`IRQ_SE0_END_BIT]     = module_enable &
                                          ~live_single_ended_zero &
                                          se0_q;
        irq_event[`IRQ_RESUME_DONE_BIT] = resume_held & ~resume_held_q;
    end

    // Sticky status, write one to clear; a new event wins
    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1) begin : g_irq
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    irq_status[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_status[gi] <= 1'b1;
                end else if (status_write && reg_wdata[gi]) begin
                    irq_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= `IRQ_RESET;
        end else if (mask_write) begin
            irq_mask <= reg_wdata[`IRQ_WIDTH-1:0];
        end
    end

    // Level output, high while any enabled status bit is set
    assign irq = |(irq_status & irq_mask);

    // --------------------------------------------------------
    // Read views
    // --------------------------------------------------------

    // Bits 7 and 0 are not implemented and read as zero
    assign control_view = {
        1'b0,
        pingpong_pointer_reset,
        live_single_ended_zero,
        pkt_disable,
        module_enable,
        resume_request,
        suspend_request,
        1'b0
    };

    assign state_view = {
        4'h0,
        pingpong_pointer_force_even,
        pullup_drive,
        engine_clock_enable,
        resume_held
    };

    // --------------------------------------------------------
    // Read data
    // --------------------------------------------------------

    // Unmapped addresses and idle cycles return zero
    always @* begin
        next_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                `USB_CONTROL_ADDR: begin
                    next_rdata = control_view;
                end
                `IRQ_STATUS_ADDR: begin
                    next_rdata = {4'h0, irq_status};
                end
                `IRQ_MASK_ADDR: begin
                    next_rdata = {4'h0, irq_mask};
                end
                `ENGINE_STATE_ADDR: begin
                    next_rdata = state_view;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // Data stands only in the cycle after the read strobe
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// ===== logic/usb_control_regs.vh
// Contract
// - Enable activates engine, clears buffer indicators
// - Enable also switches configured pull-ups on
// - Other control bits ignored while disabled
// - Bit 5 reads live single-ended zero
// - Pointer reset bit forces even banks
// - SETUP token sets packet disable, halts processing
// - Software may clear packet disable, never set
// - Resume bit drives resume; firmware holds 10 ms
// - Suspend stops engine clock, transceiver held idle
// - Bits 7, 0 read zero; others reset zero
`ifndef USB_CONTROL_REGS_VH
`define USB_CONTROL_REGS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define USB_CONTROL_ADDR      4'h0
`define IRQ_STATUS_ADDR       4'h1
`define IRQ_MASK_ADDR         4'h2
`define ENGINE_STATE_ADDR     4'h3

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CTL_SUSPEND_BIT       1
`define CTL_RESUME_BIT        2
`define CTL_ENABLE_BIT        3
`define CTL_PKT_DISABLE_BIT   4
`define CTL_SE0_BIT           5
`define CTL_PP_RESET_BIT      6

// ------------------------------------------------------------
// Interrupt status and mask fields
// ------------------------------------------------------------
`define IRQ_SETUP_BIT         0
`define IRQ_SE0_START_BIT     1
`define IRQ_SE0_END_BIT       2
`define IRQ_RESUME_DONE_BIT   3
`define IRQ_WIDTH             4

// ------------------------------------------------------------
// Engine state register fields
// ------------------------------------------------------------
`define ST_RESUME_HELD_BIT    0
`define ST_CLOCK_RUN_BIT      1
`define ST_PULLUP_BIT         2
`define ST_FORCE_EVEN_BIT     3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CONTROL_RESET         8'h00
`define IRQ_RESET             4'h0
`define PP_MODE_NONE          2'h0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CORE_CLK_KHZ          100000
`define RESUME_HOLD_MS        10
`define RESUME_HOLD_CYCLES    (`RESUME_HOLD_MS * `CORE_CLK_KHZ)
`define RESUME_CNT_WIDTH      20

`endif

// ===== logic/sync_two_ff.v
`default_nettype none

// ------------------------------------------------------------
// Two-stage level synchroniser
// ------------------------------------------------------------
module sync_two_ff #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             rst_n,
    // Level in and out
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta;

    // First stage feeds only the second, to contain metastability
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {WIDTH{1'b0}};
            q    <= {WIDTH{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

// ===== dv/usb_device_top_control_assertions.sv
`default_nettype none

module usb_device_top_control_checker (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // Configuration and bus side
    input wire logic       pullup_config_enable,
    input wire logic [1:0] pingpong_config,
    input wire logic       bus_se0_raw,
    input wire logic       setup_token_toggle,
    // Engine control
    input wire logic       engine_enable,
    input wire logic       engine_clock_enable,
    input wire logic       packet_processing_disable,
    input wire logic       pingpong_buffer_indicator_clear,
    input wire logic       pingpong_pointer_force_even,
    input wire logic       pullup_drive,
    input wire logic       resume_drive,
    input wire logic       transceiver_idle
);
    // ----------------
    // Control register strobes
    // ----------------
    wire ctl_rd = reg_read && reg_addr == 4'h0;
    wire ctl_wr = reg_write && reg_addr == 4'h0;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ----------------
    // Properties
    // ----------------
    property p_enable_clear;
        $rose(engine_enable) |-> pingpong_buffer_indicator_clear
            ##1 !pingpong_buffer_indicator_clear;
    endproperty
    a_enable_clear: assert property (p_enable_clear)
        else $error("indicator clear pulse wrong");
    property p_enable_write;
        ctl_wr && reg_wdata[3] |-> ##2 engine_enable;
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("engine not enabled after write");
    property p_pullup;
        engine_enable |-> pullup_drive == $past(pullup_config_enable);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up drive wrong");
    // Pull-up, resume, idle, clock enable and force even must be gated by the enable
    property p_quiet;
        !engine_enable |-> !(pullup_drive || resume_drive ||
            transceiver_idle || engine_clock_enable ||
            pingpong_pointer_force_even);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("output active while disabled");
    // Stable line so the synchroniser lag cannot matter
    property p_se0;
        $stable(bus_se0_raw)[*4] ##0 ctl_rd
            |=> reg_rdata[5] == $past(bus_se0_raw);
    endproperty
    a_se0: assert property (p_se0)
        else $error("live bit wrong");
    property p_force_even;
        pingpong_pointer_force_even
            |-> engine_enable && $past(pingpong_config) != 2'h0;
    endproperty
    a_force_even: assert property (p_force_even)
        else $error("force even without ping-pong mode");
    property p_setup;
        ($changed(setup_token_toggle) && engine_enable)
            ##1 (engine_enable && !reg_write)[*5]
            |-> packet_processing_disable;
    endproperty
    a_setup: assert property (p_setup)
        else $error("setup did not disable packets");
    property p_clear;
        $stable(setup_token_toggle)[*4] ##0 (ctl_wr && !reg_wdata[4])
            |=> !packet_processing_disable;
    endproperty
    a_clear: assert property (p_clear)
        else $error("packet disable not cleared");
    property p_bits_zero;
        ctl_rd |=> !reg_rdata[7] && !reg_rdata[0];
    endproperty
    a_bits_zero: assert property (p_bits_zero)
        else $error("unused control bit set");
    property p_resume;
        resume_drive |-> engine_enable && !transceiver_idle;
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume driven while off or idle");
    property p_suspend;
        engine_enable |-> engine_clock_enable != transceiver_idle;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("clock gate and idle disagree");
endmodule

bind usb_device_top_control usb_device_top_control_checker checker_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pullup_config_enable(pullup_config_enable),
    .pingpong_config(pingpong_config), .bus_se0_raw(bus_se0_raw),
    .setup_token_toggle(setup_token_toggle),
    .engine_enable(engine_enable),
    .engine_clock_enable(engine_clock_enable),
    .packet_processing_disable(packet_processing_disable),
    .pingpong_buffer_indicator_clear(pingpong_buffer_indicator_clear),
    .pingpong_pointer_force_even(pingpong_pointer_force_even),
    .pullup_drive(pullup_drive), .resume_drive(resume_drive),
    .transceiver_idle(transceiver_idle)
);
`default_nettype wire

// ===== dv/usb_host_model.sv
`default_nettype none

module usb_host_model (
    // Pacing clock only; bus lines are asynchronous
    input  wire logic core_clk,
    // Bus indications
    output var  logic bus_se0_raw,
    output var  logic setup_token_toggle
);
    timeunit 1ns;
    timeprecision 1ps;
    // Toggle must stay put through reset or a token is invented
    initial {bus_se0_raw, setup_token_toggle} = 2'h0;
    // One token per flip; gap keeps flips countable
    task automatic send_setup();
        @(posedge core_clk);
        setup_token_toggle <= ~setup_token_toggle;
        repeat (4) @(posedge core_clk);
    endtask
    // Line level changes right after a core edge
    task automatic drive_se0(input logic level);
        @(posedge core_clk);
        bus_se0_raw <= level;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_usb_device_top_control.sv
`default_nettype none

module tb_usb_device_top_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic       pullup_config_enable = 1'b0;
    logic [1:0] pingpong_config = 2'h2;
    logic [7:0] reg_rdata;
    logic [7:0] outs;
    logic       bus_se0_raw, setup_token_toggle, engine_enable,
                engine_clock_enable, packet_processing_disable,
                pingpong_buffer_indicator_clear, irq,
                pingpong_pointer_force_even, pullup_drive,
                resume_drive, transceiver_idle;
    int         failures = 0;
    int         cmp_count = 0;

    always #5 core_clk = ~core_clk;
    // Engine outputs packed for one-line checks
    assign outs = {packet_processing_disable, engine_enable,
        engine_clock_enable, pingpong_buffer_indicator_clear,
        pingpong_pointer_force_even, pullup_drive, resume_drive,
        transceiver_idle};

    // Short hold count keeps the wake-up test brief
    usb_device_top_control #(.RESUME_HOLD_CYCLES(20))
        usb_device_top_control_i (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .pullup_config_enable(pullup_config_enable),
        .pingpong_config(pingpong_config), .bus_se0_raw(bus_se0_raw),
        .setup_token_toggle(setup_token_toggle),
        .engine_enable(engine_enable),
        .engine_clock_enable(engine_clock_enable),
        .packet_processing_disable(packet_processing_disable),
        .pingpong_buffer_indicator_clear(pingpong_buffer_indicator_clear),
        .pingpong_pointer_force_even(pingpong_pointer_force_even),
        .pullup_drive(pullup_drive), .resume_drive(resume_drive),
        .transceiver_idle(transceiver_idle), .irq(irq));
    usb_host_model usb_host_model_i (.core_clk(core_clk),
        .bus_se0_raw(bus_se0_raw), .setup_token_toggle(setup_token_toggle));

    // ----------------
    // Bus and compare helpers
    // ----------------
    task check(input string what, input logic [7:0] exp,
               input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rdc(input string what, input logic [3:0] a,
             input logic [7:0] m, input logic [7:0] exp);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 check(what, exp, reg_rdata & m);
    endtask
    task ticks(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task t_reset();
        check("outputs", 8'h00, outs);
        rdc("control", 4'h0, 8'hff, 8'h00);
        rdc("unmapped", 4'h9, 8'hff, 8'h00);
    endtask
    task t_disabled();
        wr(4'h0, 8'h56);
        usb_host_model_i.send_setup();
        ticks(4);
        check("outputs", 8'h00, outs);
        rdc("status", 4'h1, 8'hff, 8'h00);
        wr(4'h0, 8'h00);
    endtask
    task t_enable();
        @(posedge core_clk);
        pullup_config_enable <= 1'b1;
        wr(4'h0, 8'h08);
        ticks(1);
        check("enable", 8'h74, outs);
        ticks(1);
        check("enabled", 8'h64, outs);
        wr(4'h0, 8'h00);
        ticks(1);
        check("detach", 8'h00, outs);
        wr(4'h0, 8'h08);
        ticks(2);
        check("attach", 8'h64, outs);
    endtask
    task t_pingpong();
        @(posedge core_clk);
        pingpong_config <= 2'h0;
        wr(4'h0, 8'h48);
        ticks(2);
        check("no ping-pong", 8'h00, outs & 8'h08);
        @(posedge core_clk);
        pingpong_config <= 2'h2;
        ticks(10);
        check("force even", 8'h08, outs & 8'h08);
        rdc("reset bit", 4'h0, 8'h40, 8'h40);
        wr(4'h0, 8'h08);
        ticks(2);
        check("released", 8'h00, outs & 8'h08);
    endtask
    task t_setup();
        wr(4'h2, 8'h00);
        usb_host_model_i.send_setup();
        ticks(1);
        check("flag", 8'h80, outs & 8'h80);
        check("masked irq", 8'h00, {7'h00, irq});
        rdc("pkt bit", 4'h0, 8'h10, 8'h10);
        rdc("status", 4'h1, 8'hff, 8'h01);
        wr(4'h2, 8'h01);
        ticks(0);
        check("irq", 8'h01, {7'h00, irq});
        wr(4'h1, 8'h01);
        ticks(0);
        check("irq cleared", 8'h00, {7'h00, irq});
        wr(4'h0, 8'h18);
        ticks(0);
        check("kept", 8'h80, outs & 8'h80);
        wr(4'h0, 8'h08);
        wr(4'h0, 8'h18);
        ticks(0);
        check("not set", 8'h00, outs & 8'h80);
    endtask
    task t_resume();
        wr(4'h2, 8'h08);
        wr(4'h0, 8'h0c);
        ticks(2);
        check("resume", 8'h02, outs & 8'h02);
        rdc("early", 4'h3, 8'h01, 8'h00);
        ticks(20);
        rdc("held", 4'h3, 8'h01, 8'h01);
        check("hold irq", 8'h01, {7'h00, irq});
        wr(4'h0, 8'h08);
        wr(4'h1, 8'h08);
        ticks(1);
        check("resume off", 8'h00, outs & 8'h02);
        check("irq off", 8'h00, {7'h00, irq});
    endtask
    task t_suspend();
        wr(4'h0, 8'h0a);
        ticks(2);
        check("suspend", 8'h45, outs);
        wr(4'h0, 8'h0e);
        ticks(2);
        check("no resume", 8'h45, outs);
        wr(4'h0, 8'h08);
        ticks(2);
        check("wake", 8'h64, outs);
    endtask
    task t_se0();
        wr(4'h2, 8'h06);
        usb_host_model_i.drive_se0(1'b1);
        ticks(4);
        rdc("se0 on", 4'h0, 8'h20, 8'h20);
        check("se0 irq", 8'h01, {7'h00, irq});
        usb_host_model_i.drive_se0(1'b0);
        ticks(4);
        rdc("se0 off", 4'h0, 8'h20, 8'h00);
        rdc("se0 status", 4'h1, 8'h06, 8'h06);
        wr(4'h1, 8'h06);
        ticks(0);
        check("se0 clear", 8'h00, {7'h00, irq});
    endtask

    // ----------------
    // Run control
    // ----------------
    task complete_run();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_disabled();
        t_enable();
        t_pingpong();
        t_setup();
        t_resume();
        t_suspend();
        t_se0();
        complete_run();
    end
    // Whole run is about 150 cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
